// file: hdl/modem_rx_map.svh
// constants: timing, rates, stream layout and reset values
`ifndef MODEM_RX_MAP_SVH
`define MODEM_RX_MAP_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define CLK_HZ        125000000
`define T_ON_MS       105
`define T_OFF_PSK_MS  10
`define T_OFF_FSK_MS  25
`define MS_CYC(ms)    ((ms) * (`CLK_HZ / 1000))
`define CD_CNT_W      24

// ----------------------------------------------------------------
// bit clock rates in hertz
// ----------------------------------------------------------------
`define F_UART_HI     19200
`define F_UART_MID    9600
`define F_UART_FSK    4800
`define F_SYNC_HI     1200
`define F_SYNC_LO     600
`define NCO_INC(f)    32'((64'(f) << 32) / 64'(`CLK_HZ))

// ----------------------------------------------------------------
// descrambler and converter
// ----------------------------------------------------------------
`define DSC_LEN       17
`define DSC_TAP_A     13
`define DSC_TAP_B     16
`define UNLOCK_ONES   7'd64
`define DATA_BITS_MIN 4'd6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CD_N_RST      1'b1
`define CLK_OUT_RST   1'b1
`define TXD_IDLE      1'b1

`endif

// file: hdl/modem_rx_pkg.sv
// types shared by the receive control block
package modem_rx_pkg;

  // ----------------------------------------------------------------
  // mode straps from the controller
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       sync_mode;   // 1 synchronous, 0 asynchronous
    logic       bell;        // 1 bell family, 0 ccitt
    logic       bit_rate_select;
    logic       originate;   // 1 originate, 0 answer
    logic       aloop;       // analog loop selected
    logic       dloop;       // digital loop selected
    logic       rts;         // request to send
    logic [1:0] len_sel;     // character length 8..11 bits
  } mode_s;

  // ----------------------------------------------------------------
  // state machines
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CD_OFF   = 2'b00,
    CD_QUAL  = 2'b01,
    CD_ON    = 2'b10,
    CD_DROP  = 2'b11
  } cd_state_e;

  typedef enum logic [1:0] {
    C_HUNT   = 2'b00,
    C_DATA   = 2'b01,
    C_STOP   = 2'b10,
    C_BREAK  = 2'b11
  } conv_state_e;

endpackage

// file: hdl/modem_rx_ctrl.sv
// receive control: descrambler, converter, carrier detect, clocks
// How it works
// [RL1] dpsk demodulated bits pass a descrambler before the terminal data, fsk bits bypass it
// [RL2] ccitt mode: 64 ones at input invert next bit before descrambling
// [RL3] async mode: buffer characters, reinsert deleted stop bits
// [RL4] break characters are forwarded unchanged
// [RL5] carrier detect is low while valid carrier is present
// [RL6] carrier must stand 105 to 205 ms before detect goes low
// [RL7] loss: 10 to 24 ms dpsk, 25 to 75 ms fsk before release
// [RL8] analog loop puts receiver on the transmit channel
// [RL9] outside circuit loops transmit carrier to receive input
// [RL10] digital loop: rx data, rx clock, detect onto tx side
// [RL11] sync mode bit clocks act as circuits 114, 113, 115
// [RL12] async: tx clock held high, rx clock is uart baud clock
// [RL13] sync: 1200 or 600 hz clocks; fsk: tx high, rx 4.8 khz
// [RL14] buffered master oscillator copy on a clock output
// [RL15] line monitor: filter clock from terminal transmit clock
// [RL16] line monitor: fast envelope style carrier detect
// [RL17] line monitor: filter centre scales with monitor clock
// [RL18] outside party derives monitor clock from master clock
// [RL19] loop reset on detect release, fsk/dpsk swap, channel swap
// [RL20] firmware triggers a loop reset before dpsk carrier
// [RL21] originate receives high channel, answer receives low
// [RL22] detect starts inactive high with timers cleared
`include "modem_rx_map.svh"
module modem_rx_ctrl #(
  parameter int unsigned ON_CYC      = `MS_CYC(`T_ON_MS),
  parameter int unsigned OFF_PSK_CYC = `MS_CYC(`T_OFF_PSK_MS),
  parameter int unsigned OFF_FSK_CYC = `MS_CYC(`T_OFF_FSK_MS)
) (
  input  wire logic                 CLK,
  input  wire logic                 RSTN,
  input  wire logic                 CE,
  input  wire modem_rx_pkg::mode_s  MODE,
  input  wire logic                 OSC_IN,
  input  wire logic                 CARRIER_IN,
  input  wire logic                 TERMINAL_TRANSMIT_CLOCK_IN,
  input  wire logic                 TXD_IN,
  input  wire logic                 DEMOD_BIT,
  input  wire logic                 DEMOD_VALID,
  output logic                      DEMOD_READY,
  output logic                      RXD_DATA,
  output logic                      RXD_VALID,
  input  wire logic                 RXD_READY,
  output logic                      CARRIER_DETECT_OUT_N,
  output logic                      TRANSMIT_BIT_CLOCK_OUT,
  output logic                      RECEIVE_BIT_CLOCK_OUT,
  output logic                      MASTER_CLOCK_OUT,
  output logic                      FILTER_CLK_OUT,
  output logic                      RX_HIGH_CHANNEL,
  output logic                      CARRIER_RECOVERY_LOOP_RESET,
  output logic                      LOOP_TXD,
  output logic                      LOOP_TX_CLK,
  output logic                      LOOP_RTS
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int PW = $bits(modem_rx_pkg::mode_s) + 4;
  // transmit data resets to mark so loop data stays idle after reset
  localparam logic [PW-1:0] PIN_RST = {{(PW-1){1'b0}}, `TXD_IDLE};
  logic [PW-1:0] pin_v;
  logic [PW-1:0] s1_ff;
  logic [PW-1:0] s2_ff;
  assign pin_v = {MODE, OSC_IN, CARRIER_IN,
                  TERMINAL_TRANSMIT_CLOCK_IN, TXD_IN};

  // two flops per pin, first stage read only by the second
  for (genvar g = 0; g < PW; g++) begin : g_sync
    always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
        s1_ff[g] <= PIN_RST[g];
        s2_ff[g] <= PIN_RST[g];
      end else if (CE) begin
        s1_ff[g] <= pin_v[g];
        s2_ff[g] <= s1_ff[g];
      end
    end
  end

  modem_rx_pkg::mode_s md;
  logic                osc_s;
  logic                car_s;
  logic                tclk_s;
  logic                txd_s;
  assign md     = modem_rx_pkg::mode_s'(s2_ff[PW-1:4]);
  assign osc_s  = s2_ff[3];
  assign car_s  = s2_ff[2];
  assign tclk_s = s2_ff[1];
  assign txd_s  = s2_ff[0];

  // mode decode
  logic fsk;
  logic lm;
  logic conv_on;
  assign fsk     = md.bell & md.bit_rate_select;
  assign lm      = ~md.sync_mode & md.rts;
  assign conv_on = ~md.sync_mode & ~fsk;

  // ----------------------------------------------------------------
  // descrambler with unlock detection
  // ----------------------------------------------------------------
  logic [`DSC_LEN-1:0] sr_ff;
  logic [6:0]          ones_ff;
  logic                pend_ff;
  logic                fifo_rdy;
  logic                acc;
  logic                hit;
  logic                eff_in;
  logic                dsc_bit;

  assign DEMOD_READY = CE & fifo_rdy & ~pend_ff;
  assign acc     = DEMOD_VALID & DEMOD_READY;
  assign hit     = ~md.bell & ~fsk & (ones_ff == `UNLOCK_ONES); // RL2
  assign eff_in  = DEMOD_BIT ^ hit; // RL2
  assign dsc_bit = fsk ? DEMOD_BIT
                 : eff_in ^ sr_ff[`DSC_TAP_A] ^ sr_ff[`DSC_TAP_B]; // RL1

  // shift line bits and count runs of ones
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sr_ff   <= '0;
      ones_ff <= 7'h00;
    end else if (CE && acc && !fsk) begin
      sr_ff   <= {sr_ff[`DSC_LEN-2:0], eff_in};
      ones_ff <= (DEMOD_BIT && !hit) ? ones_ff + 7'h01 : 7'h00;
    end
  end

  // ----------------------------------------------------------------
  // asynchronous character converter
  // ----------------------------------------------------------------
  modem_rx_pkg::conv_state_e cst_ff;
  modem_rx_pkg::conv_state_e nxt_cst;
  logic [3:0] bcnt_ff;
  logic [3:0] nxt_bcnt;
  logic       zero_ff;
  logic       nxt_zero;
  logic       nxt_pend;
  logic       ins;
  logic       push;
  logic       push_bit;
  logic [3:0] ndata;

  assign ndata    = `DATA_BITS_MIN + {2'b00, md.len_sel};
  assign ins      = conv_on & acc & (cst_ff == modem_rx_pkg::C_STOP)
                  & ~dsc_bit & ~zero_ff; // RL3
  assign push     = acc | (pend_ff & fifo_rdy & CE);
  assign push_bit = pend_ff ? 1'b0 : (ins | dsc_bit); // RL3

  // character framing: stop check, break pass, stop reinsertion
  always_comb begin
    nxt_cst  = cst_ff;
    nxt_bcnt = bcnt_ff;
    nxt_zero = zero_ff;
    nxt_pend = pend_ff & ~fifo_rdy;
    if (!conv_on) begin
      nxt_cst = modem_rx_pkg::C_HUNT;
    end else if (acc) begin
      unique case (cst_ff)
        modem_rx_pkg::C_HUNT: begin
          nxt_bcnt = 4'h0;
          nxt_zero = 1'b1;
          if (!dsc_bit) nxt_cst = modem_rx_pkg::C_DATA;
        end
        modem_rx_pkg::C_DATA: begin
          nxt_zero = zero_ff & ~dsc_bit;
          nxt_bcnt = bcnt_ff + 4'h1;
          if (bcnt_ff == ndata - 4'h1) nxt_cst = modem_rx_pkg::C_STOP;
        end
        modem_rx_pkg::C_STOP: begin
          if (dsc_bit) begin
            nxt_cst = modem_rx_pkg::C_HUNT;
          end else if (zero_ff) begin
            nxt_cst = modem_rx_pkg::C_BREAK; // RL4
          end else begin
            nxt_cst  = modem_rx_pkg::C_DATA; // RL3
            nxt_bcnt = 4'h0;
            nxt_zero = 1'b1;
            nxt_pend = 1'b1;
          end
        end
        modem_rx_pkg::C_BREAK: begin
          if (dsc_bit) nxt_cst = modem_rx_pkg::C_HUNT; // RL4
        end
      endcase
    end
  end

  // converter registers
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cst_ff  <= modem_rx_pkg::C_HUNT;
      bcnt_ff <= 4'h0;
      zero_ff <= 1'b0;
      pend_ff <= 1'b0;
    end else if (CE) begin
      cst_ff  <= nxt_cst;
      bcnt_ff <= nxt_bcnt;
      zero_ff <= nxt_zero;
      pend_ff <= nxt_pend;
    end
  end

  // ----------------------------------------------------------------
  // two-entry receive buffer
  // ----------------------------------------------------------------
  logic [1:0] mem_ff;
  logic       wp_ff;
  logic       rp_ff;
  logic [1:0] cnt_ff;
  logic       pop;
  assign fifo_rdy  = (cnt_ff != 2'd2);
  assign RXD_VALID = CE & (cnt_ff != 2'd0);
  assign RXD_DATA  = mem_ff[rp_ff];
  assign pop       = RXD_VALID & RXD_READY;

  // buffer pointers and storage
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mem_ff <= 2'b00;
      wp_ff  <= 1'b0;
      rp_ff  <= 1'b0;
      cnt_ff <= 2'd0;
    end else if (CE) begin
      if (push) mem_ff[wp_ff] <= push_bit;
      if (push) wp_ff <= ~wp_ff;
      if (pop) rp_ff <= ~rp_ff;
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  // ----------------------------------------------------------------
  // carrier detect qualification
  // ----------------------------------------------------------------
  modem_rx_pkg::cd_state_e cd_ff;
  modem_rx_pkg::cd_state_e nxt_cd;
  logic [`CD_CNT_W-1:0] tmr_ff;
  logic [`CD_CNT_W-1:0] nxt_tmr;
  logic [`CD_CNT_W-1:0] on_lim;
  logic [`CD_CNT_W-1:0] off_lim;
  logic                 cd_n_ff;
  logic                 nxt_cd_n;
  assign on_lim  = `CD_CNT_W'(ON_CYC - 1);
  assign off_lim = fsk ? `CD_CNT_W'(OFF_FSK_CYC - 1)
                       : `CD_CNT_W'(OFF_PSK_CYC - 1); // RL7

  // qualify rise and fall; monitor mode skips the timers
  always_comb begin
    nxt_cd  = cd_ff;
    nxt_tmr = tmr_ff + `CD_CNT_W'(1);
    unique case (cd_ff)
      modem_rx_pkg::CD_OFF: begin
        nxt_tmr = '0;
        if (car_s) nxt_cd = lm ? modem_rx_pkg::CD_ON
                               : modem_rx_pkg::CD_QUAL; // RL16
      end
      modem_rx_pkg::CD_QUAL: begin
        if (!car_s) nxt_cd = modem_rx_pkg::CD_OFF;
        else if (lm || tmr_ff == on_lim) nxt_cd = modem_rx_pkg::CD_ON; // RL6
      end
      modem_rx_pkg::CD_ON: begin
        nxt_tmr = '0;
        if (!car_s) nxt_cd = lm ? modem_rx_pkg::CD_OFF
                                : modem_rx_pkg::CD_DROP; // RL16
      end
      modem_rx_pkg::CD_DROP: begin
        if (car_s) nxt_cd = modem_rx_pkg::CD_ON;
        else if (lm || tmr_ff == off_lim) nxt_cd = modem_rx_pkg::CD_OFF; // RL7
      end
    endcase
  end
  assign nxt_cd_n = ~nxt_cd[1]; // RL5

  // detector registers, inactive after reset
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cd_ff   <= modem_rx_pkg::CD_OFF; // RL22
      tmr_ff  <= '0;
      cd_n_ff <= `CD_N_RST; // RL22
    end else if (CE) begin
      cd_ff   <= nxt_cd;
      tmr_ff  <= nxt_tmr;
      cd_n_ff <= nxt_cd_n; // RL5
    end
  end
  assign CARRIER_DETECT_OUT_N = cd_n_ff;

  // ----------------------------------------------------------------
  // bit clock generation
  // ----------------------------------------------------------------
  function automatic logic [31:0] rate_inc(modem_rx_pkg::mode_s m);
    logic f;
    f = m.bell & m.bit_rate_select;
    if (f) rate_inc = `NCO_INC(`F_UART_FSK); // RL13
    else if (!m.sync_mode)
      rate_inc = m.bit_rate_select ? `NCO_INC(`F_UART_MID)
                                   : `NCO_INC(`F_UART_HI); // RL12
    else
      rate_inc = m.bit_rate_select ? `NCO_INC(`F_SYNC_LO)
                                   : `NCO_INC(`F_SYNC_HI); // RL13
  endfunction

  logic [31:0] nco_ff;
  logic        chan_nxt;
  logic        evt;
  logic        fsk_ff;
  assign chan_nxt = md.originate ^ md.aloop; // RL8
  assign evt = (nxt_cd_n & ~cd_n_ff) | (fsk != fsk_ff)
             | (chan_nxt != RX_HIGH_CHANNEL); // RL19

  // clocks, routing and loop reset outputs
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      nco_ff                      <= 32'h0000_0000;
      TRANSMIT_BIT_CLOCK_OUT      <= `CLK_OUT_RST;
      RECEIVE_BIT_CLOCK_OUT       <= `CLK_OUT_RST;
      MASTER_CLOCK_OUT            <= 1'b0;
      FILTER_CLK_OUT              <= 1'b0;
      RX_HIGH_CHANNEL             <= 1'b0;
      fsk_ff                      <= 1'b0;
      CARRIER_RECOVERY_LOOP_RESET <= 1'b0;
      LOOP_TXD                    <= 1'b1;
      LOOP_TX_CLK                 <= 1'b0;
      LOOP_RTS                    <= 1'b0;
    end else if (CE) begin
      nco_ff <= nco_ff + rate_inc(md);
      TRANSMIT_BIT_CLOCK_OUT <= (md.sync_mode && !fsk)
                              ? nco_ff[31] : 1'b1; // RL11 RL12 RL13
      RECEIVE_BIT_CLOCK_OUT  <= nco_ff[31]; // RL11
      MASTER_CLOCK_OUT <= osc_s; // RL14
      FILTER_CLK_OUT   <= lm ? tclk_s : osc_s; // RL15 RL17
      RX_HIGH_CHANNEL  <= chan_nxt; // RL21
      fsk_ff <= fsk;
      CARRIER_RECOVERY_LOOP_RESET <= evt; // RL19
      LOOP_TXD    <= md.dloop ? RXD_DATA : txd_s; // RL10
      LOOP_TX_CLK <= md.dloop ? RECEIVE_BIT_CLOCK_OUT : tclk_s; // RL10
      LOOP_RTS    <= md.dloop ? ~cd_n_ff : md.rts; // RL10
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RSTN);

  descr_path_a: assert property ( // RL1
    CE && acc && !fsk && md.sync_mode && cnt_ff == 2'd0 |=>
    RXD_VALID == CE && RXD_DATA == $past(dsc_bit)
  ) else $error("descrambled bit not buffered");
  unlock_inv_a: assert property ( // RL2
    acc && ones_ff == `UNLOCK_ONES && !md.bell && !fsk
    |=> sr_ff[0] == !$past(DEMOD_BIT) && ones_ff == 7'h00
  ) else $error("unlock bit not inverted");
  stop_ins_a: assert property ( // RL3
    CE && ins && RXD_READY |-> push && push_bit ##1 pend_ff && !DEMOD_READY
  ) else $error("stop bit not reinserted");
  break_pass_a: assert property ( // RL4
    acc && conv_on && cst_ff == modem_rx_pkg::C_BREAK
    |-> push && push_bit == dsc_bit
  ) else $error("break altered");
  cd_on_a: assert property ( // RL6
    CE && cd_ff == modem_rx_pkg::CD_QUAL && car_s && tmr_ff == on_lim
    |=> !CARRIER_DETECT_OUT_N
  ) else $error("detect not asserted at timeout");
  cd_off_a: assert property ( // RL7
    CE && cd_ff == modem_rx_pkg::CD_DROP && !car_s && tmr_ff == off_lim
    |=> CARRIER_DETECT_OUT_N
  ) else $error("detect not released at timeout");
  cd_wait_a: assert property ( // RL5
    cd_ff == modem_rx_pkg::CD_QUAL |-> CARRIER_DETECT_OUT_N
  ) else $error("detect active before qualification");
  async_clk_a: assert property ( // RL12
    CE && !md.sync_mode |=> TRANSMIT_BIT_CLOCK_OUT
  ) else $error("tx clock not held in async");
  dloop_rts_a: assert property ( // RL10
    CE && md.dloop |=> LOOP_RTS == !$past(CARRIER_DETECT_OUT_N)
  ) else $error("detect not looped to rts");
  loop_rst_a: assert property ( // RL19
    CE && $rose(CARRIER_DETECT_OUT_N) |-> CARRIER_RECOVERY_LOOP_RESET
  ) else $error("no loop reset on detect release");
  mon_clk_a: assert property ( // RL15
    CE && lm |=> FILTER_CLK_OUT == $past(tclk_s)
  ) else $error("filter clock not from terminal clock");
  chan_sel_a: assert property ( // RL8
    CE |=> RX_HIGH_CHANNEL == $past(md.originate ^ md.aloop)
  ) else $error("receive channel wrong");

  stop_ins_c:  cover property (ins);
  break_c:     cover property (cst_ff == modem_rx_pkg::C_BREAK);
  cd_on_c:     cover property ($fell(CARRIER_DETECT_OUT_N));
  unlock_c:    cover property (acc && hit);

endmodule

// file: bench/dte_model.sv
// terminal side model: stalling receiver and terminal transmit clock
module dte_model (
  input  wire logic clk,
  input  wire logic stall_en,
  input  wire logic hold,
  input  wire logic rxd_data,
  input  wire logic rxd_valid,
  output logic      rxd_ready,
  output logic      term_clk,
  output logic      txd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic got[$];

  // ------------------------------------------------------------
  // terminal transmit clock, the bench clock divided by eight
  // ------------------------------------------------------------
  initial begin
    term_clk = 1'b0;
    txd = 1'b1;
    forever begin
      repeat (4) @(negedge clk);
      term_clk = ~term_clk;
    end
  end

  // fresh transmit data on each falling terminal clock
  always @(negedge term_clk) begin
    txd <= 1'($urandom_range(0, 1));
  end

  // ------------------------------------------------------------
  // receive side: random stalls, bit kept when both sides high
  // ------------------------------------------------------------
  initial rxd_ready = 1'b0;
  always @(negedge clk) begin
    rxd_ready <= !hold && !(stall_en && $urandom_range(0, 2) == 0);
    #3;
    if (rxd_valid === 1'b1 && rxd_ready === 1'b1) got.push_back(rxd_data);
  end
endmodule

// file: bench/modem_rx_ctrl_tb.sv
// self-checking bench for the modem receive control block
`include "modem_rx_map.svh"
module modem_rx_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ON_C  = 40;
  localparam int OFF_P = 10;
  localparam int OFF_F = 20;
  localparam logic [41:0] A_IN =
    42'b1111_01011011_01100110_1001011_00000000_000_1_111;
  localparam logic [42:0] A_EX =
    43'b1111_01011011_01100111_0_1001011_00000000_000_1_111;

  logic                clk, rstn, ce, osc, car, dbit, dvalid;
  logic                stall, hold, ce_rand;
  modem_rx_pkg::mode_s mode;
  wire logic           dready, rxd, rxv, rxr, cdn, txc, rxc, mco;
  wire logic           fclk, hich, lrst, ltxd, ltclk, lrts, tclk, txd;
  int                  errors = 0;
  int                  compares = 0;
  int                  lr_cnt = 0;
  logic [16:0]         sr;
  logic [6:0]          ones;
  logic                exp_q[$];

  modem_rx_ctrl #(.ON_CYC(ON_C), .OFF_PSK_CYC(OFF_P), .OFF_FSK_CYC(OFF_F))
  i_dut (
    .CLK(clk), .RSTN(rstn), .CE(ce), .MODE(mode), .OSC_IN(osc),
    .CARRIER_IN(car), .TERMINAL_TRANSMIT_CLOCK_IN(tclk), .TXD_IN(txd),
    .DEMOD_BIT(dbit), .DEMOD_VALID(dvalid), .DEMOD_READY(dready),
    .RXD_DATA(rxd), .RXD_VALID(rxv), .RXD_READY(rxr),
    .CARRIER_DETECT_OUT_N(cdn), .TRANSMIT_BIT_CLOCK_OUT(txc),
    .RECEIVE_BIT_CLOCK_OUT(rxc), .MASTER_CLOCK_OUT(mco),
    .FILTER_CLK_OUT(fclk), .RX_HIGH_CHANNEL(hich),
    .CARRIER_RECOVERY_LOOP_RESET(lrst), .LOOP_TXD(ltxd),
    .LOOP_TX_CLK(ltclk), .LOOP_RTS(lrts)
  );

  dte_model i_dte (
    .clk(clk), .stall_en(stall), .hold(hold), .rxd_data(rxd),
    .rxd_valid(rxv), .rxd_ready(rxr), .term_clk(tclk), .txd(txd)
  );

  // ------------------------------------------------------------
  // clock, loop reset pulse counter, watchdog
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(negedge clk) begin
    if (lrst === 1'b1) lr_cnt++;
  end
  initial begin
    #760_000;
    errors++;
    $display("[ERR] watchdog expected finish seen timeout");
    final_report();
  end

  // ------------------------------------------------------------
  // checks and expectation functions
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic rng(input string what, input int lo, input int hi,
                     input int got);
    compares++;
    if (got < lo || got > hi) begin
      errors++;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic final_report();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // descrambler with unlock detection on its input
  function automatic logic dsc(input logic x);
    if (ones == `UNLOCK_ONES) begin
      x = ~x;
      ones = 7'd0;
    end else begin
      ones = x ? ones + 7'd1 : 7'd0;
    end
    dsc = x ^ sr[13] ^ sr[16];
    sr = {sr[15:0], x};
  endfunction

  // scrambler: line bit that descrambles to y
  function automatic logic scr(input logic y);
    scr = y ^ sr[13] ^ sr[16];
    sr = {sr[15:0], scr};
  endfunction

  // ------------------------------------------------------------
  // drivers and measurements
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic do_reset();
    @(negedge clk);
    rstn = 1'b0;
    cyc(20);
    rstn = 1'b1;
    sr = '0;
    ones = '0;
    i_dte.got.delete();
    exp_q.delete();
  endtask

  // offer one bit, held until taken
  task automatic send(input logic b);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      dvalid = 1'b1;
      dbit = b;
      if (ce_rand) ce = ($urandom_range(0, 9) != 0);
      #3;
      n++;
      if (ce === 1'b0) chk("rx valid while frozen", 0, rxv);
    end while (dready !== 1'b1 && n < 200);
    rng("demod handshake wait", 1, 199, n);
  endtask

  task automatic drain(input string what);
    int n;
    int mm;
    @(negedge clk);
    dvalid = 1'b0;
    n = 0;
    mm = 0;
    while (i_dte.got.size() < exp_q.size() && n < 2000) begin
      @(negedge clk);
      n++;
    end
    cyc(10);
    foreach (exp_q[i]) begin
      if (i >= i_dte.got.size() || i_dte.got[i] !== exp_q[i]) mm++;
    end
    chk({what, " length"}, exp_q.size(), i_dte.got.size());
    chk({what, " bit errors"}, 0, mm);
  endtask

  task automatic cd_time(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    @(negedge clk);
    car = lvl;
    while (cdn !== ~lvl && n < 400) begin
      @(negedge clk);
      n++;
    end
    rng("carrier detect delay", lo, hi, n);
  endtask

  task automatic bclk(input int half);
    int   n;
    logic p;
    logic tx_ok;
    tx_ok = 1'b1;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      p = rxc;
      while (rxc === p && n < 30000) begin
        @(negedge clk);
        n++;
        if (txc !== 1'b1) tx_ok = 1'b0;
      end
    end
    rng("rx bit clock half period", half - 3, half + 3, n);
    chk("tx bit clock held high", 1, tx_ok);
  endtask

  task automatic tg(input logic which, input int lo, input int hi);
    int   n;
    logic p;
    n = 0;
    p = which ? ltclk : fclk;
    repeat (64) begin
      @(negedge clk);
      if ((which ? ltclk : fclk) !== p) n++;
      p = which ? ltclk : fclk;
    end
    rng("forwarded clock toggles", lo, hi, n);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    int          lr0;
    int          n;
    int          taken;
    logic        ch0;
    logic        b;
    logic        e;
    logic [2:0]  m_tab[4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    int unsigned f_tab[4] = '{`F_UART_HI, `F_UART_MID, `F_UART_FSK,
                              `F_UART_FSK};
    rstn = 1'b0;
    ce = 1'b1;
    osc = 1'b0;
    car = 1'b0;
    dbit = 1'b0;
    dvalid = 1'b0;
    stall = 1'b0;
    hold = 1'b0;
    ce_rand = 1'b0;
    mode = '0;
    void'($urandom(32'h33cc));
    do_reset();
    cyc(1);
    chk("detect idle after reset", 1, cdn);
    chk("rx valid after reset", 0, rxv);
    chk("loop tx data after reset", 1, ltxd);
    // carrier qualify and release, burst restart, fsk release
    lr0 = lr_cnt;
    cd_time(1'b1, ON_C + 1, ON_C + 6);
    cd_time(1'b0, OFF_P + 1, OFF_P + 6);
    cyc(3);
    chk("loop reset on release", lr0 + 1, lr_cnt);
    car = 1'b1;
    cyc(ON_C / 2);
    car = 1'b0;
    cyc(4);
    chk("detect after short burst", 1, cdn);
    cd_time(1'b1, ON_C + 1, ON_C + 6);
    lr0 = lr_cnt;
    {mode.bell, mode.bit_rate_select} = 2'b11;
    cyc(6);
    chk("loop reset on fsk swap", lr0 + 1, lr_cnt);
    cd_time(1'b0, OFF_F + 1, OFF_F + 6);
    mode = '0;
    mode.rts = 1'b1;
    cyc(6);
    cd_time(1'b1, 1, 6);
    tg(1'b0, 14, 18);
    cd_time(1'b0, 1, 6);
    mode.rts = 1'b0;
    cyc(6);
    tg(1'b0, 0, 0);
    // receive channel over originate and analog loop
    for (int k = 0; k < 4; k++) begin
      lr0 = lr_cnt;
      ch0 = hich;
      mode.originate = k[0];
      mode.aloop = k[1];
      cyc(6);
      chk("receive channel", 32'(k[0] ^ k[1]), hich);
      chk("loop reset on channel", lr0 + 32'(hich !== ch0), lr_cnt);
    end
    // master clock copy latency
    for (int k = 0; k < 4; k++) begin
      n = 0;
      osc = ~osc;
      while (mco !== osc && n < 20) begin
        @(negedge clk);
        n++;
      end
      rng("master clock copy latency", 2, 4, n);
      cyc(3);
    end
    // bit clock rates, then digital loop
    for (int k = 0; k < 4; k++) begin
      mode = '0;
      {mode.sync_mode, mode.bell, mode.bit_rate_select} = m_tab[k];
      cyc(6);
      bclk(`CLK_HZ / (2 * f_tab[k]));
    end
    mode = '0;
    tg(1'b1, 14, 18);
    mode.dloop = 1'b1;
    cyc(6);
    bclk(`CLK_HZ / (2 * `F_UART_HI));
    cyc(3);
    chk("loop tx clock from rx clock", rxc, ltclk);
    chk("loop tx data from rx data", rxd, ltxd);
    chk("loop rts from detect", !cdn, lrts);
    // async converter: insertion and break
    mode = '0;
    mode.bell = 1'b1;
    do_reset();
    cyc(4);
    stall = 1'b1;
    for (int i = 41; i >= 0; i--) send(scr(A_IN[i]));
    for (int i = 42; i >= 0; i--) exp_q.push_back(A_EX[i]);
    drain("async stream");
    // sync stream: buffer fill, unlock run, random data
    mode = '0;
    mode.sync_mode = 1'b1;
    do_reset();
    cyc(4);
    hold = 1'b1;
    cyc(2);
    taken = 0;
    for (int k = 0; k < 6; k++) begin
      @(negedge clk);
      dvalid = 1'b1;
      dbit = 1'b0;
      #3;
      if (dready === 1'b1) begin
        exp_q.push_back(dsc(1'b0));
        taken++;
      end
    end
    rng("buffer depth", 2, 2, taken);
    @(negedge clk);
    hold = 1'b0;
    ce_rand = 1'b1;
    for (int i = 0; i < 400; i++) begin
      b = (i >= 100 && i < 170) ? 1'b1 : 1'($urandom_range(0, 1));
      e = dsc(b);
      send(b);
      exp_q.push_back(e);
    end
    ce_rand = 1'b0;
    ce = 1'b1;
    drain("sync stream");
    final_report();
  end
endmodule
